// ---- bench/pcl_host.sv ----
`timescale 1ns/10ps
module pcl_host (
  input wire logic link_clk_in,
  input wire logic link_busy_in,
  input wire logic link_done_in,
  input wire logic [15:0] link_rdata_in,
  output logic link_req_out,
  output logic link_write_out,
  output logic [7:0] link_code_out,
  output logic [15:0] link_wdata_out
);
  // idle link cycles before each request, to act as a slow host
  int gap = 0;
  initial begin
    link_req_out = 1'b0;
    link_write_out = 1'b0;
    link_code_out = 8'h00;
    link_wdata_out = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] rd);
    int n;
    n = 0;
    rd = 16'hXXXX;
    repeat (gap + 1) @(posedge link_clk_in);
    #1;
    link_req_out = 1'b1;
    link_write_out = w;
    link_code_out = c;
    link_wdata_out = d;
    @(posedge link_clk_in);
    #1;
    link_req_out = 1'b0;
    // scrambled once taken so a late capture cannot pass unseen
    link_write_out = ~w;
    link_code_out = ~c;
    link_wdata_out = ~d;
    while (n < 40) begin
      @(posedge link_clk_in);
      #1;
      if (link_done_in === 1'b1) begin
        rd = link_rdata_in;
        n = 40;
      end
      n++;
    end
  endtask
endmodule

// ---- bench/pcl_regs_chk.sv ----
`timescale 1ns/10ps
module pcl_regs_chk (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic link_clk_in,
  input wire logic link_req_in,
  input wire logic conv_en_in,
  input wire logic [15:0] vout_command_in,
  input wire logic [15:0] vout_sense_in,
  input wire logic link_busy_out,
  input wire logic link_done_out,
  input wire logic [15:0] link_rdata_out,
  input wire logic power_stage_en_out,
  input wire logic [5:0] ov_step_out,
  input wire logic smbalert_n_out
);
  logic over;
  // widened so the product never wraps at full scale
  assign over = 32'(vout_sense_in) * 32'h28 >
                32'(vout_command_in) * 32'(ov_step_out);
  sequence taken_s;
    link_req_in && !link_busy_out;
  endsequence
  sequence answered_s;
    link_done_out && !link_busy_out;
  endsequence
  busy_on_take_a: assert property (@(posedge link_clk_in)
    disable iff (!rstn_in) taken_s |=> link_busy_out)
    else $error("request taken without busy");
  answer_due_a: assert property (@(posedge link_clk_in)
    disable iff (!rstn_in) taken_s |-> ##[2:12] answered_s)
    else $error("no answer in time");
  busy_ends_a: assert property (@(posedge link_clk_in)
    disable iff (!rstn_in) link_busy_out |=> link_busy_out || link_done_out)
    else $error("busy dropped without done");
  done_pulse_a: assert property (@(posedge link_clk_in)
    disable iff (!rstn_in) link_done_out |=> !link_done_out)
    else $error("done longer than one cycle");
  rdata_hold_a: assert property (@(posedge link_clk_in)
    disable iff (!rstn_in) $past(rstn_in) && $changed(link_rdata_out) |->
    link_done_out)
    else $error("read data moved without done");
  step_span_a: assert property (@(posedge clk_sys_in)
    disable iff (!rstn_in) ov_step_out inside {[6'h2A:6'h38]})
    else $error("threshold step out of span");
  step_idle_a: assert property (@(posedge clk_sys_in)
    disable iff (!rstn_in) !conv_en_in [*6] |->
    ov_step_out inside {6'h2C, 6'h30, 6'h34, 6'h38})
    else $error("idle threshold off the coarse grid");
  ov_alert_a: assert property (@(posedge clk_sys_in)
    disable iff (!rstn_in) over |-> ##[1:6] !smbalert_n_out)
    else $error("overvoltage without alert");
  stage_off_a: assert property (@(posedge clk_sys_in)
    disable iff (!rstn_in) !conv_en_in [*4] |-> !power_stage_en_out)
    else $error("power stage on while disabled");
endmodule

bind pcl_regs pcl_regs_chk chk_u (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .link_clk_in(link_clk_in),
  .link_req_in(link_req_in), .conv_en_in(conv_en_in),
  .vout_command_in(vout_command_in), .vout_sense_in(vout_sense_in),
  .link_busy_out(link_busy_out), .link_done_out(link_done_out),
  .link_rdata_out(link_rdata_out), .power_stage_en_out(power_stage_en_out),
  .ov_step_out(ov_step_out), .smbalert_n_out(smbalert_n_out)
);

// ---- bench/tb.sv ----
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rstn = 1'b0;
  logic req, wr, busy, done, pen, alert_n;
  logic alone, conv, abs_m, store, rest;
  logic [2:0] nph;
  logic [5:0] step;
  logic [7:0] code;
  logic [15:0] wd, rdat, vcmd, vsen, isen, riout;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;
  initial begin
    #7;
    forever #62.5 lclk = ~lclk;
  end

  pcl_regs #(.TON_RISE_CYC(20)) dut_u (
    .clk_sys_in(clk), .rstn_in(rstn), .link_clk_in(lclk),
    .link_req_in(req), .link_write_in(wr), .link_code_in(code),
    .link_wdata_in(wd), .stand_alone_in(alone), .stack_phases_in(nph),
    .conv_en_in(conv), .vout_mode_abs_in(abs_m),
    .vout_command_in(vcmd), .vout_sense_in(vsen), .iout_sensed_in(isen),
    .nvm_store_in(store), .nvm_restore_in(rest),
    .link_busy_out(busy), .link_done_out(done), .link_rdata_out(rdat),
    .power_stage_en_out(pen), .ov_step_out(step),
    .read_iout_out(riout), .smbalert_n_out(alert_n)
  );

  pcl_host host_u (
    .link_clk_in(lclk), .link_busy_in(busy), .link_done_in(done),
    .link_rdata_in(rdat), .link_req_out(req), .link_write_out(wr),
    .link_code_out(code), .link_wdata_out(wd)
  );

  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("[FAIL] run length expected below 20000 seen %0d", cycles);
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_bit(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr16(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] v;
    host_u.xfer(1'b1, c, d, v);
  endtask
  task automatic rdchk(input string what, input logic [7:0] c,
                       input logic [15:0] e);
    logic [15:0] v;
    host_u.xfer(1'b0, c, 16'h0000, v);
    chk(what, e, v);
  endtask
  task automatic rdbit(input string what, input logic [7:0] c,
                       input int b, input logic e);
    logic [15:0] v;
    host_u.xfer(1'b0, c, 16'h0000, v);
    chk_bit(what, e, v[b]);
  endtask
  task automatic wait_pen(input logic v, input int n);
    while (pen !== v && n > 0) begin
      cyc(1);
      n--;
    end
    chk_bit("power stage", v, pen);
  endtask
  // held past two link edges, longer than the plain four cycles
  task automatic do_reset(input logic sa);
    cyc(1);
    alone = sa;
    rstn = 1'b0;
    cyc(12);
    rstn = 1'b1;
    cyc(20);
  endtask
  task automatic pulse_nvm();
    cyc(1);
    store = 1'b1;
    cyc(1);
    store = 1'b0;
    rest = 1'b1;
    cyc(1);
    rest = 1'b0;
    cyc(4);
  endtask

  task automatic t_reset_vals();
    rdchk("gain rst", 8'h38, 16'hC880);
    rdchk("offs rst", 8'h39, 16'hE000);
    rdchk("ovlim rst", 8'h40, 16'h0266);
    chk("step rst", 16'h0030, {10'h000, step});
    chk("iout rst", 16'hE000, riout);
    chk_bit("alert rst", 1'b1, alert_n);
  endtask

  task automatic t_gain();
    wr16(8'h38, 16'hC8C0);
    rdchk("gain rw", 8'h38, 16'hC8C0);
    cyc(1);
    isen = 16'h0010;
    cyc(8);
    chk("iout gain", 16'hE018, riout);
    rdchk("iout read", 8'h8C, 16'hE018);
    wr16(8'h38, 16'hC980);
    rdchk("gain bad", 8'h38, 16'hC8C0);
    rdbit("bad data", 8'h7E, 6, 1'b1);
    chk_bit("alert bad", 1'b0, alert_n);
    wr16(8'h03, 16'h0000);
    chk_bit("alert clr", 1'b1, alert_n);
  endtask

  task automatic t_nvm();
    wr16(8'h04, 16'h0000);
    wr16(8'h39, 16'hD005);
    rdchk("offs fine", 8'h39, 16'hD005);
    wr16(8'h38, 16'hC0C1);
    pulse_nvm();
    rdchk("gain round", 8'h38, 16'hD030);
    rdchk("offs nvm", 8'h39, 16'hE001);
    wr16(8'h38, 16'hC1FE);
    pulse_nvm();
    rdchk("gain clamp", 8'h38, 16'hD07F);
  endtask

  task automatic t_offs();
    host_u.gap = 3;
    wr16(8'h38, 16'hC880);
    wr16(8'h04, 16'h0000);
    wr16(8'h39, 16'hE010);
    wr16(8'h04, 16'h0001);
    wr16(8'h39, 16'hE020);
    rdchk("offs ph1", 8'h39, 16'hE020);
    wr16(8'h04, 16'h0000);
    rdchk("offs ph0", 8'h39, 16'hE010);
    wr16(8'h04, 16'h00FF);
    rdchk("offs all", 8'h39, 16'hE040);
    rdchk("phase rd", 8'h04, 16'h00FF);
    wr16(8'h39, 16'hE080);
    wr16(8'h04, 16'h0003);
    rdchk("offs div", 8'h39, 16'hE020);
    cyc(8);
    chk("iout sum", 16'hE090, riout);
    wr16(8'h39, 16'hE201);
    rdchk("offs bad", 8'h39, 16'hE020);
    host_u.gap = 0;
  endtask

  task automatic t_ov();
    logic [15:0] lim [4] = '{16'h0200, 16'h0233, 16'h0241, 16'h02CC};
    logic [5:0] es [2][4] = '{'{6'h2A, 6'h2C, 6'h2E, 6'h38},
                              '{6'h2C, 6'h2C, 6'h30, 6'h38}};
    for (int k = 0; k < 2; k++) begin
      cyc(1);
      conv = (k == 0);
      for (int i = 0; i < 4; i++) begin
        wr16(8'h40, lim[i]);
        cyc(4);
        chk("ov step", {10'h000, es[k][i]}, {10'h000, step});
      end
    end
    wr16(8'h40, 16'h02E0);
    rdchk("ov bad", 8'h40, 16'h02CC);
    rdbit("ov bad data", 8'h7E, 6, 1'b1);
    wr16(8'h03, 16'h0000);
    cyc(1);
    abs_m = 1'b1;
    conv = 1'b1;
    wr16(8'h40, 16'h0480);
    cyc(4);
    chk("ov abs", 16'h002D, {10'h000, step});
    vcmd = 16'h0440;
    cyc(4);
    rdchk("ov kept", 8'h40, 16'h0480);
    vcmd = 16'h0400;
    abs_m = 1'b0;
  endtask

  task automatic t_fault();
    cyc(1);
    conv = 1'b0;
    wr16(8'h40, 16'h0233);
    cyc(1);
    vsen = 16'h04B0;
    cyc(8);
    rdbit("ov while off", 8'h7A, 7, 1'b1);
    vsen = 16'h0400;
    wr16(8'h03, 16'h0000);
    wr16(8'h41, 16'h00C0);
    rdchk("resp bad", 8'h41, 16'h0080);
    rdbit("resp bad data", 8'h7E, 6, 1'b1);
    wr16(8'h41, 16'h0000);
    wr16(8'h03, 16'h0000);
    cyc(1);
    conv = 1'b1;
    wait_pen(1'b1, 100);
    vsen = 16'h04B0;
    cyc(10);
    chk_bit("ignore runs", 1'b1, pen);
    rdchk("status byte", 8'h78, 16'h0020);
    rdbit("status word", 8'h79, 15, 1'b1);
    rdchk("status vout", 8'h7A, 16'h0080);
    chk_bit("alert ov", 1'b0, alert_n);
    cyc(1);
    vsen = 16'h0400;
    wr16(8'h03, 16'h0000);
    wr16(8'h41, 16'h0040);
    cyc(1);
    vsen = 16'h04B0;
    wait_pen(1'b0, 20);
    vsen = 16'h0400;
    cyc(200);
    chk_bit("latched off", 1'b0, pen);
    conv = 1'b0;
    cyc(8);
    conv = 1'b1;
    wr16(8'h03, 16'h0000);
    wait_pen(1'b1, 100);
    wr16(8'h41, 16'h0088);
    cyc(1);
    vsen = 16'h04B0;
    wait_pen(1'b0, 20);
    vsen = 16'h0400;
    wait_pen(1'b1, 100);
  endtask

  task automatic t_ilv();
    wr16(8'h37, 16'h0021);
    rdchk("ilv stack", 8'h37, 16'h0010);
    rdbit("ilv refused", 8'h7E, 7, 1'b1);
    do_reset(1'b1);
    wr16(8'h37, 16'h0021);
    rdchk("ilv alone", 8'h37, 16'h0021);
  endtask

  initial begin
    alone = 1'b0;
    nph = 3'h4;
    conv = 1'b0;
    abs_m = 1'b0;
    store = 1'b0;
    rest = 1'b0;
    vcmd = 16'h0400;
    vsen = 16'h0400;
    isen = 16'h0000;
    cyc(4);
    rstn = 1'b1;
    cyc(20);
    t_reset_vals();
    t_gain();
    t_nvm();
    t_offs();
    t_ov();
    t_fault();
    t_ilv();
    tally_and_finish();
  end
endmodule

// ---- rtl/pcl_defines.svh ----
`ifndef PCL_DEFINES_SVH
`define PCL_DEFINES_SVH
// command codes
`define PCL_CMD_PHASE 8'h04
`define PCL_CMD_CLEAR 8'h03
`define PCL_CMD_ILV 8'h37
`define PCL_CMD_GAIN 8'h38
`define PCL_CMD_OFFS 8'h39
`define PCL_CMD_OVLIM 8'h40
`define PCL_CMD_OVRESP 8'h41
`define PCL_CMD_STBYTE 8'h78
`define PCL_CMD_STWORD 8'h79
`define PCL_CMD_STVOUT 8'h7A
`define PCL_CMD_STCML 8'h7E
`define PCL_CMD_IOUT 8'h8C
// reset values
`define PCL_GAIN_EXP_RST 5'h19
`define PCL_GAIN_MAN_RST 11'h080
`define PCL_OFFS_EXP_RST 5'h1C
`define PCL_OFFS_MAN_RST 11'h000
`define PCL_OVLIM_RST 16'h0266
`define PCL_OV_CODE_RST 6'd48
`define PCL_OVRESP_RST 8'h80
`define PCL_ILV_RST 16'h0010
`define PCL_PHASE_ALL 8'hFF
// restored gain: exponent -6, mantissa at most 127
`define PCL_GAIN_NVM_EXP 5'h1A
`define PCL_GAIN_NVM_MAX 11'h07F
// limits in 1/1024 units
`define PCL_GAIN_MAX_Q10 32'sd2048
`define PCL_OFFS_MAX_Q10 32'sd8192
// relative one for ULINEAR16 relative format
`define PCL_OV_REL_ONE 16'h0200
// threshold steps in units of 2.5 percent
`define PCL_OV_STEP_MIN 6'd42
`define PCL_OV_STEP_MAX 6'd56
`define PCL_OV_STEP_OFF_MIN 6'd44
`define PCL_OV_STEP_DIV 32'd40
// status bit positions
`define PCL_SB_VOUT_OV 5
`define PCL_SB_CML 1
`define PCL_SW_VOUT 15
`define PCL_SV_OVF 7
`define PCL_CML_BADCMD 7
`define PCL_CML_BADDATA 6
`define PCL_RETRY_FOREVER 3'd7
`define PCL_RESP_IGNORE 2'b00
`define PCL_RESP_BAD 2'b11
`define PCL_NPH 4
`endif

// ---- rtl/pcl_pkg.sv ----
package pcl_pkg;
  typedef enum logic [2:0] {
    PCL_ST_OFF, PCL_ST_RUN, PCL_ST_HICCUP, PCL_ST_PROVE, PCL_ST_LATCH
  } pcl_ov_state_t;

  typedef struct packed {
    logic wr;
    logic [7:0] code;
    logic [15:0] wdata;
  } pcl_req_t;

  typedef struct packed {
    logic req_tgl;
    pcl_req_t req;
    logic busy;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic ack_seen;
    logic done;
    logic [15:0] rdata;
  } pcl_link_state_t;

  typedef struct packed {
    logic rq_s1;
    logic rq_s2;
    logic rq_s3;
    logic rq_seen;
    logic ack_tgl;
    logic [15:0] rdata;
    logic [3:0] strap_s1;
    logic [3:0] strap_s2;
    logic [3:0] strap_s3;
    logic [1:0] strap_cnt;
    logic standalone;
    logic [2:0] nphase;
    logic [15:0] phase_position_command;
    logic [15:0] gain;
    logic [7:0] phase_sel;
    logic [3:0][15:0] offs;
    logic [15:0] ov_limit;
    logic [5:0] ov_code;
    logic [7:0] ov_resp;
    logic [15:0] nvm_gain;
    logic [3:0][15:0] nvm_offs;
    logic ovf;
    logic [7:0] cml;
    pcl_ov_state_t st;
    logic [23:0] cnt;
    logic [2:0] tries;
    logic pstage;
    logic [5:0] step;
    logic [15:0] iout;
    logic alert_n;
  } pcl_sys_state_t;
endpackage

// ---- rtl/pcl_regs.sv ----
`timescale 1ns/10ps
`include "pcl_defines.svh"
// Function
// [R1] phase-phase_position_command command writable only if strapped stand-alone at power-on
// [R2] gain trim multiplies sensed output current before it is reported
// [R3] gain trim resets to unity with exponent 11001b
// [R4] gain trim word is signed linear, exponent 15:11, mantissa 10:0
// [R5] out-of-range gain, offset or overvoltage writes flag invalid data
// [R6] restore rounds gain to nearest 1/64, clamped to 127/64
// [R7] offset trim is per phase; stack offset is sum of phases
// [R8] offset trim is signed linear with exponent reset 11100b
// [R9] restore gives stored supported option; finer writes accepted in range
// [R10] phase 00h-03h selects one phase for offset reads and writes
// [R11] phase FFh write gives every phase the value divided by phases
// [R12] phase FFh read returns phase zero offset times phase count
// [R13] overvoltage threshold stays relative to present output voltage target
// [R14] output target change leaves stored absolute limit unchanged
// [R15] overvoltage detection armed from reset release regardless of enable
// [R16] running: limit rounds up to 105-140 percent in 2.5 steps
// [R17] conversion off: threshold only 110-140 percent in 10 steps
// [R18] detected overvoltage acts per programmed response setting
// [R19] response 00b ignore, 01b/10b shut down and retry, 11b invalid
// [R20] retry 0 latches, 1-6 restarts after hiccup, 7 forever
// [R21] overvoltage sets status byte, word, output status and alerts host
// [R22] absolute limit converted to percent of present target, then rounded
module pcl_regs
  import pcl_pkg::*;
#(
  parameter int TON_RISE_CYC = 40000
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic link_clk_in,
  input wire logic link_req_in,
  input wire logic link_write_in,
  input wire logic [7:0] link_code_in,
  input wire logic [15:0] link_wdata_in,
  input wire logic stand_alone_in,
  input wire logic [2:0] stack_phases_in,
  input wire logic conv_en_in,
  input wire logic vout_mode_abs_in,
  input wire logic [15:0] vout_command_in,
  input wire logic [15:0] vout_sense_in,
  input wire logic [15:0] iout_sensed_in,
  input wire logic nvm_store_in,
  input wire logic nvm_restore_in,
  output logic link_busy_out,
  output logic link_done_out,
  output logic [15:0] link_rdata_out,
  output logic power_stage_en_out,
  output logic [5:0] ov_step_out,
  output logic [15:0] read_iout_out,
  output logic smbalert_n_out
);
  logic [1:0] srst_r;
  logic [1:0] lrst_r;
  logic srstn;
  logic lrstn;
  pcl_sys_state_t s_r, s_nxt;
  pcl_link_state_t l_r, l_nxt;

  // linear word to signed value with ten fraction bits
  function automatic logic signed [31:0] lin_q10(input logic [15:0] w);
    logic signed [5:0] sh;
    logic signed [31:0] m;
    sh = 6'(signed'(w[15:11])) + 6'sd10;
    m = 32'(signed'(w[10:0]));
    if (sh >= 0) begin
      lin_q10 = m <<< sh[4:0];
    end else begin
      lin_q10 = m >>> 5'(-sh);
    end
  endfunction

  // q10 value to exponent -4 linear word, rounded and clamped
  function automatic logic [15:0] q10_to_q4(input logic signed [31:0] q);
    logic signed [31:0] m;
    m = (q + 32'sd32) >>> 6;
    if (m > 32'sd1023) begin
      m = 32'sd1023;
    end else if (m < -32'sd1024) begin
      m = -32'sd1024;
    end
    q10_to_q4 = {`PCL_OFFS_EXP_RST, m[10:0]};
  endfunction

  // smallest 2.5 percent step at or above limit; 0 when above 140
  function automatic logic [5:0] ov_round(input logic [15:0] v,
                                          input logic [15:0] ref_v);
    logic [5:0] k;
    logic found;
    ov_round = 6'd0;
    found = 1'b0;
    for (int i = 0; i <= 14; i++) begin
      k = `PCL_OV_STEP_MIN + 6'(i);
      if (!found && 32'(v) * `PCL_OV_STEP_DIV <= 32'(ref_v) * 32'(k)) begin
        found = 1'b1;
        ov_round = k;
      end
    end
  endfunction

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      srst_r <= 2'b00;
    end else begin
      srst_r <= {srst_r[0], 1'b1};
    end
  end
  assign srstn = srst_r[1];

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lrst_r <= 2'b00;
    end else begin
      lrst_r <= {lrst_r[0], 1'b1};
    end
  end
  assign lrstn = lrst_r[1];

  // link side: one request in flight, held stable until acknowledged
  always_comb begin
    l_nxt = l_r;
    l_nxt.done = 1'b0;
    l_nxt.ack_s1 = s_r.ack_tgl;
    l_nxt.ack_s2 = l_r.ack_s1;
    l_nxt.ack_s3 = l_r.ack_s2;
    if (link_req_in && !l_r.busy) begin
      l_nxt.req = '{wr: link_write_in, code: link_code_in,
                    wdata: link_wdata_in};
      l_nxt.req_tgl = ~l_r.req_tgl;
      l_nxt.busy = 1'b1;
    end
    if (l_r.ack_s2 == l_r.ack_s3 && l_r.ack_s3 != l_r.ack_seen) begin
      l_nxt.ack_seen = l_r.ack_s3;
      l_nxt.done = 1'b1;
      l_nxt.busy = 1'b0;
      l_nxt.rdata = s_r.rdata;
    end
  end

  always_ff @(posedge link_clk_in or negedge lrstn) begin
    if (!lrstn) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  always_comb begin
    logic signed [31:0] q;
    logic signed [31:0] tot;
    logic signed [47:0] prod;
    logic [5:0] code;
    logic [5:0] hw;
    logic [15:0] ref_v;
    logic fault;
    logic go;
    logic bad;
    logic [23:0] period;
    q = '0;
    tot = '0;
    prod = '0;
    code = '0;
    bad = 1'b0;
    hw = '0;
    ref_v = '0;
    fault = 1'b0;
    go = 1'b0;
    period = '0;
    s_nxt = s_r;
    // synchronisers
    s_nxt.rq_s1 = l_r.req_tgl;
    s_nxt.rq_s2 = s_r.rq_s1;
    s_nxt.rq_s3 = s_r.rq_s2;
    s_nxt.strap_s1 = {stand_alone_in, stack_phases_in};
    s_nxt.strap_s2 = s_r.strap_s1;
    s_nxt.strap_s3 = s_r.strap_s2;
    // straps sampled on each of the first three cycles that the synchroniser is steady past release, then held
    if (s_r.strap_cnt != 2'd3 && s_r.strap_s2 == s_r.strap_s3) begin
      s_nxt.strap_cnt = s_r.strap_cnt + 2'd1;
      s_nxt.standalone = s_r.strap_s3[3]; // [R1]
      s_nxt.nphase = (s_r.strap_s3[2:0] == 3'd0) ? 3'd1 :
                     (s_r.strap_s3[2:0] > 3'd4) ? 3'd4 : s_r.strap_s3[2:0];
    end
    // hardware threshold relative to the target, mode aside
    hw = s_r.ov_code; // [R13] [R16]
    if (!conv_en_in) begin
      hw = (s_r.ov_code <= `PCL_OV_STEP_OFF_MIN) ? `PCL_OV_STEP_OFF_MIN :
           ((s_r.ov_code + 6'd3) & 6'h3C); // [R17]
    end
    s_nxt.step = hw;
    // armed from reset onward, whatever the enable
    fault = 32'(vout_sense_in) * `PCL_OV_STEP_DIV >
            32'(vout_command_in) * 32'(hw); // [R15]
    // register access
    go = s_r.rq_s2 == s_r.rq_s3 && s_r.rq_s3 != s_r.rq_seen;
    if (go) begin
      s_nxt.rq_seen = s_r.rq_s3;
      s_nxt.ack_tgl = ~s_r.ack_tgl;
      s_nxt.rdata = '0;
      if (l_r.req.wr) begin
        case (l_r.req.code)
          `PCL_CMD_CLEAR: begin
            s_nxt.ovf = 1'b0;
            s_nxt.cml = '0;
          end
          `PCL_CMD_PHASE: s_nxt.phase_sel = l_r.req.wdata[7:0];
          `PCL_CMD_ILV: begin
            if (s_r.standalone) begin
              s_nxt.phase_position_command = {4'h0, l_r.req.wdata[11:0]}; // [R1]
            end else begin
              s_nxt.cml[`PCL_CML_BADCMD] = 1'b1; // [R1]
            end
          end
          `PCL_CMD_GAIN: begin
            q = lin_q10(l_r.req.wdata);
            if (q < 0 || q > `PCL_GAIN_MAX_Q10) begin
              bad = 1'b1; // [R5]
            end else begin
              s_nxt.gain = l_r.req.wdata; // [R4]
            end
          end
          `PCL_CMD_OFFS: begin
            q = lin_q10(l_r.req.wdata);
            if (q < -`PCL_OFFS_MAX_Q10 || q > `PCL_OFFS_MAX_Q10) begin
              bad = 1'b1; // [R5] [R9]
            end else if (s_r.phase_sel == `PCL_PHASE_ALL) begin
              q = q / $signed({29'd0, s_r.nphase});
              for (int i = 0; i < `PCL_NPH; i++) begin
                if (i < int'(s_r.nphase)) begin
                  s_nxt.offs[i] = q10_to_q4(q); // [R11]
                end
              end
            end else if (s_r.phase_sel < 8'(`PCL_NPH)) begin
              s_nxt.offs[s_r.phase_sel[1:0]] = l_r.req.wdata; // [R10]
            end else begin
              bad = 1'b1;
            end
          end
          `PCL_CMD_OVLIM: begin
            ref_v = vout_mode_abs_in ? vout_command_in : `PCL_OV_REL_ONE;
            code = ov_round(l_r.req.wdata, ref_v); // [R22] [R16]
            if (code == 6'd0 || ref_v == 16'd0) begin
              bad = 1'b1; // [R5]
            end else begin
              s_nxt.ov_limit = l_r.req.wdata; // [R14]
              s_nxt.ov_code = code;
            end
          end
          `PCL_CMD_OVRESP: begin
            if (l_r.req.wdata[7:6] == `PCL_RESP_BAD) begin
              bad = 1'b1; // [R19]
            end else begin
              s_nxt.ov_resp = l_r.req.wdata[7:0];
            end
          end
          default: s_nxt.cml[`PCL_CML_BADCMD] = 1'b1;
        endcase
      end else begin
        case (l_r.req.code)
          `PCL_CMD_PHASE: s_nxt.rdata = {8'h00, s_r.phase_sel};
          `PCL_CMD_ILV: s_nxt.rdata = s_r.phase_position_command;
          `PCL_CMD_GAIN: s_nxt.rdata = s_r.gain;
          `PCL_CMD_OFFS: begin
            if (s_r.phase_sel == `PCL_PHASE_ALL) begin
              q = lin_q10(s_r.offs[0]) * $signed({29'd0, s_r.nphase});
              s_nxt.rdata = q10_to_q4(q); // [R12]
            end else if (s_r.phase_sel < 8'(`PCL_NPH)) begin
              s_nxt.rdata = s_r.offs[s_r.phase_sel[1:0]]; // [R10]
            end
          end
          `PCL_CMD_OVLIM: s_nxt.rdata = s_r.ov_limit;
          `PCL_CMD_OVRESP: s_nxt.rdata = {8'h00, s_r.ov_resp};
          `PCL_CMD_STBYTE: s_nxt.rdata = {8'h00, 2'b00, s_r.ovf, 3'b000,
                                          |s_r.cml, 1'b0}; // [R21]
          `PCL_CMD_STWORD: s_nxt.rdata = {s_r.ovf, 7'h00, 2'b00, s_r.ovf,
                                          3'b000, |s_r.cml, 1'b0}; // [R21]
          `PCL_CMD_STVOUT: s_nxt.rdata = {8'h00, s_r.ovf, 7'h00};
          `PCL_CMD_STCML: s_nxt.rdata = {8'h00, s_r.cml};
          `PCL_CMD_IOUT: s_nxt.rdata = s_r.iout; // [R2]
          default: s_nxt.cml[`PCL_CML_BADCMD] = 1'b1;
        endcase
      end
    end
    if (bad) begin
      s_nxt.cml[`PCL_CML_BADDATA] = 1'b1; // [R5]
    end
    // nvm keeps only the coarse supported options
    if (nvm_store_in || nvm_restore_in) begin
      q = (lin_q10(s_r.gain) + 32'sd8) >>> 4;
      if (q > 32'(`PCL_GAIN_NVM_MAX)) begin
        q = 32'(`PCL_GAIN_NVM_MAX);
      end
      s_nxt.gain = {`PCL_GAIN_NVM_EXP, q[10:0]}; // [R6]
      for (int i = 0; i < `PCL_NPH; i++) begin
        s_nxt.offs[i] = q10_to_q4(lin_q10(s_r.offs[i])); // [R9]
      end
      if (nvm_store_in) begin
        s_nxt.nvm_gain = s_nxt.gain;
        s_nxt.nvm_offs = s_nxt.offs;
      end else begin
        s_nxt.gain = s_r.nvm_gain;
        s_nxt.offs = s_r.nvm_offs;
      end
    end
    // reported current: gained sense plus stack offset sum
    for (int i = 0; i < `PCL_NPH; i++) begin
      if (i < int'(s_r.nphase)) begin
        tot = tot + lin_q10(s_r.offs[i]); // [R7]
      end
    end
    prod = 48'(signed'(iout_sensed_in)) * 48'(lin_q10(s_r.gain)); // [R2]
    s_nxt.iout = q10_to_q4(32'(prod >>> 4) + tot);
    // fault response
    period = 24'(TON_RISE_CYC) * (24'(s_r.ov_resp[2:0]) + 24'd1);
    if (fault) begin
      s_nxt.ovf = 1'b1; // [R21]
    end
    s_nxt.cnt = (s_r.cnt != 24'd0) ? s_r.cnt - 24'd1 : 24'd0;
    case (s_r.st)
      PCL_ST_OFF: begin
        s_nxt.tries = '0;
        if (conv_en_in && !fault) begin
          s_nxt.st = PCL_ST_RUN;
        end
      end
      PCL_ST_RUN, PCL_ST_PROVE: begin
        if (!conv_en_in) begin
          s_nxt.st = PCL_ST_OFF;
        end else if (fault &&
                     s_r.ov_resp[7:6] != `PCL_RESP_IGNORE) begin // [R18]
          if (s_r.ov_resp[5:3] == 3'd0) begin
            s_nxt.st = PCL_ST_LATCH; // [R20]
          end else begin
            s_nxt.st = PCL_ST_HICCUP; // [R19]
            s_nxt.cnt = period;
          end
        end else if (s_r.st == PCL_ST_PROVE && s_r.cnt == 24'd0) begin
          s_nxt.st = PCL_ST_RUN;
          s_nxt.tries = '0;
        end
      end
      PCL_ST_HICCUP: begin
        if (!conv_en_in) begin
          s_nxt.st = PCL_ST_OFF;
        end else if (s_r.cnt == 24'd0) begin
          if (s_r.ov_resp[5:3] == `PCL_RETRY_FOREVER ||
              s_r.tries < s_r.ov_resp[5:3]) begin // [R20]
            s_nxt.tries = (s_r.tries == 3'd7) ? 3'd7 : s_r.tries + 3'd1;
            s_nxt.st = PCL_ST_PROVE;
            s_nxt.cnt = 24'(TON_RISE_CYC) * 24'd2;
          end else begin
            s_nxt.st = PCL_ST_LATCH;
          end
        end
      end
      PCL_ST_LATCH: begin
        if (!conv_en_in) begin
          s_nxt.st = PCL_ST_OFF;
        end
      end
      default: s_nxt.st = PCL_ST_OFF;
    endcase
    s_nxt.pstage = s_nxt.st == PCL_ST_RUN || s_nxt.st == PCL_ST_PROVE;
    s_nxt.alert_n = !(s_nxt.ovf || s_nxt.cml != 8'h00); // [R21]
  end

  always_ff @(posedge clk_sys_in or negedge srstn) begin
    if (!srstn) begin
      s_r <= '0;
      s_r.gain <= {`PCL_GAIN_EXP_RST, `PCL_GAIN_MAN_RST}; // [R3]
      s_r.nvm_gain <= {`PCL_GAIN_EXP_RST, `PCL_GAIN_MAN_RST};
      s_r.offs <= {`PCL_NPH{`PCL_OFFS_EXP_RST, `PCL_OFFS_MAN_RST}}; // [R8]
      s_r.nvm_offs <= {`PCL_NPH{`PCL_OFFS_EXP_RST, `PCL_OFFS_MAN_RST}};
      s_r.ov_limit <= `PCL_OVLIM_RST;
      s_r.ov_code <= `PCL_OV_CODE_RST;
      s_r.step <= `PCL_OV_CODE_RST;
      s_r.ov_resp <= `PCL_OVRESP_RST;
      s_r.phase_position_command <= `PCL_ILV_RST;
      s_r.nphase <= 3'd1;
      s_r.standalone <= 1'b1;
      s_r.iout <= {`PCL_OFFS_EXP_RST, 11'h000};
      s_r.alert_n <= 1'b1;
      s_r.st <= PCL_ST_OFF;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link_busy_out = l_r.busy;
  assign link_done_out = l_r.done;
  assign link_rdata_out = l_r.rdata;
  assign power_stage_en_out = s_r.pstage;
  assign ov_step_out = s_r.step;
  assign read_iout_out = s_r.iout;
  assign smbalert_n_out = s_r.alert_n;
endmodule
